// *** hdl/sarc_ctrl.sv ***
// top of the 8-bit sar converter control with its ahb-lite register slave
`default_nettype none
module sarc_ctrl import sarc_pkg::*; #(
  parameter int unsigned SETTLE_LEN = SETTLE_CYCLES,
  parameter int unsigned CHANNELS = NUM_CHANNELS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // power management
  input wire logic haltMode,
  // analog front end
  output logic anaPowerOn,
  output logic [CHANNELS-1:0] anaChanSel,
  output logic anaSample,
  output logic [RES_BITS-1:0] dacCode,
  input wire logic compHigh
);

  // register state
  logic [7:0] result_q;
  logic flag_q;
  logic power_q;
  logic [CHAN_W-1:0] chan_q;
  // bus state
  logic wrCtrl_q;
  logic [31:0] hrdata_q;
  // decoded address phase
  logic addrPhase;
  logic hitResult;
  logic hitCtrl;
  logic lowLane;
  logic readResult;
  logic ctrlWrite;
  logic [7:0] ctrlView;
  // converter control
  logic convPower;
  logic settled;
  logic convRun;
  logic convAbort;
  logic convDone;
  logic [RES_BITS-1:0] convResult;

  // zero-wait slave: every transfer finishes in one data-phase cycle
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_q;

  // address phase decode; hsel already covers the slave's window
  assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign hitResult = (haddr[9:2] == RESULT_IDX);
  assign hitCtrl = (haddr[9:2] == CTRL_IDX);
  // the register byte lives in lane 0; other lanes are not written
  assign lowLane = (hsize == HSIZE_BYTE) ? (haddr[1:0] == 2'h0) :
    (hsize == HSIZE_HALF) ? !haddr[1] : 1'b1;
  assign readResult = addrPhase && !hwrite && hitResult;

  // write to the control register is applied in its data phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrCtrl_q <= 1'b0;
    end else begin
      wrCtrl_q <= addrPhase && hwrite && hitCtrl && lowLane;
    end
  end
  // writes to the result register or unmapped words are dropped
  assign ctrlWrite = wrCtrl_q;

  // control view: bits 6, 4 and 3 read zero and are never stored
  always_comb begin
    ctrlView = 8'h00;
    ctrlView[FLAG_BIT] = flag_q;
    ctrlView[POWER_BIT] = power_q;
    ctrlView[CHAN_LSB +: CHAN_W] = chan_q;
  end

  // read data captured at the address phase, shown in the data phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      if (hitResult) begin
        hrdata_q <= {24'h00_0000, result_q};
      end else if (hitCtrl) begin
        hrdata_q <= {24'h00_0000, ctrlView};
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  // software-owned power bit and channel select
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      power_q <= CTRL_RESET[POWER_BIT];
      chan_q <= CTRL_RESET[CHAN_LSB +: CHAN_W];
    end else if (ctrlWrite) begin
      power_q <= hwdata[POWER_BIT];
      chan_q <= hwdata[CHAN_LSB +: CHAN_W];
    end
  end

  // completion flag: a finishing conversion wins over any clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_q <= CTRL_RESET[FLAG_BIT];
    end else if (convDone) begin
      flag_q <= 1'b1;
    end else if (ctrlWrite) begin
      flag_q <= 1'b0;
    end else if (readResult) begin
      flag_q <= 1'b0;
    end
  end

  // result register overwritten by every finished conversion
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_q <= RESULT_RESET;
    end else if (convDone) begin
      result_q <= convResult;
    end
  end

  // halt removes analog power; wait mode is deliberately not an input
  assign convPower = power_q && !haltMode;

  // stabilisation after every power-up or halt wakeup
  sarc_settle #(
    .SETTLE_LEN(SETTLE_LEN)
  ) u_settle (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(convPower),
    .settled(settled)
  );

  // free-running conversion once settled; a write restarts from sampling
  assign convRun = convPower && settled;
  assign convAbort = ctrlWrite || !convRun;

  sarc_seq u_seq (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(convRun),
    .abort(convAbort),
    .compHigh(compHigh),
    .sampling(anaSample),
    .trialCode(dacCode),
    .done(convDone),
    .result(convResult)
  );

  // one-hot analog switch enables; the digital input path is untouched
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      assign anaChanSel[ch] = convPower &&
        (chan_q == CHAN_W'(ch));
    end
  endgenerate

  assign anaPowerOn = convPower;

endmodule
`default_nettype wire

// *** hdl/sarc_pkg.sv ***
// shared constants and types for the 8-bit sar converter control block
`default_nettype none
package sarc_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SETTLE_TIME_NS = 30000;
  localparam int unsigned SETTLE_CYCLES =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYCLES = 64;
  // sampling time kept in half cycles: 63 half cycles is 31.5 cycles
  localparam int unsigned SAMPLE_HALF_CYCLES = 63;
  localparam int unsigned SAMPLE_CYCLES = (SAMPLE_HALF_CYCLES + 1) / 2;
  localparam int unsigned RES_BITS = 8;
  localparam int unsigned BIT_CYCLES =
    (CONV_CYCLES - SAMPLE_CYCLES) / RES_BITS;
  localparam int unsigned NUM_CHANNELS = 8;

  // register indices; byte address is four times the index
  localparam logic [7:0] RESULT_IDX = 8'h70;
  localparam logic [7:0] CTRL_IDX = 8'h71;

  // control/status field positions
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned POWER_BIT = 5;
  localparam int unsigned CHAN_LSB = 0;
  localparam int unsigned CHAN_W = 3;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic HRESP_OKAY = 1'b0;

  // sequencer states, gray along idle -> sample -> convert -> sample
  typedef enum logic [1:0] {
    SARC_IDLE = 2'h0,
    SARC_SAMPLE = 2'h1,
    SARC_CONVERT = 2'h3
  } sarc_state_t;

endpackage
`default_nettype wire

// *** hdl/sarc_settle.sv ***
// stabilisation delay counter after converter power-up
`default_nettype none
module sarc_settle import sarc_pkg::*; #(
  parameter int unsigned SETTLE_LEN = SETTLE_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control and status
  input wire logic enable,
  output logic settled
);

  localparam int unsigned CW = $clog2(SETTLE_LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(SETTLE_LEN);

  logic [CW-1:0] count_q;

  // restart whenever power drops so every power-up waits the full time
  always_ff @(posedge ref_clk) begin
    if (rst || !enable) begin
      count_q <= '0;
    end else if (count_q != LAST) begin
      count_q <= count_q + 1'b1;
    end
  end

  assign settled = enable && (count_q == LAST);

endmodule
`default_nettype wire

// *** hdl/sarc_seq.sv ***
// successive approximation sequencer: sampling phase then bit decisions
`default_nettype none
module sarc_seq import sarc_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic abort,
  // analog front end
  input wire logic compHigh,
  output logic sampling,
  output logic [RES_BITS-1:0] trialCode,
  // result
  output logic done,
  output logic [RES_BITS-1:0] result
);

  localparam logic [5:0] SAMPLE_LAST = 6'(SAMPLE_CYCLES - 1);
  localparam logic [5:0] CONV_LAST = 6'(CONV_CYCLES - 1);
  localparam logic [5:0] SLOT_LAST = 6'(BIT_CYCLES - 1);
  localparam logic [RES_BITS-1:0] MSB_TRIAL = 8'h80;

  sarc_state_t state_q;
  logic [5:0] cnt_q;
  logic [RES_BITS-1:0] trial_q;
  logic [RES_BITS-1:0] bitMask_q;
  logic [RES_BITS-1:0] kept;
  logic decide;

  // decision at the last cycle of each bit slot, after the dac settles
  assign decide = (state_q == SARC_CONVERT) &&
    ((cnt_q & SLOT_LAST) == SLOT_LAST);
  // keep the trial bit only while the input is at or above the dac level
  assign kept = compHigh ? trial_q : (trial_q & ~bitMask_q);

  // state and cycle counter: 32 sample cycles, 32 conversion cycles
  always_ff @(posedge ref_clk) begin
    if (rst || abort) begin
      state_q <= SARC_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        SARC_IDLE: begin
          if (run) begin
            state_q <= SARC_SAMPLE;
            cnt_q <= '0;
          end
        end
        SARC_SAMPLE: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == SAMPLE_LAST) begin
            state_q <= SARC_CONVERT;
          end
        end
        SARC_CONVERT: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CONV_LAST) begin
            state_q <= SARC_SAMPLE;
            cnt_q <= '0;
          end
        end
        default: begin
          state_q <= SARC_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // binary search from msb down: full scale gives ff, ground gives 00
  always_ff @(posedge ref_clk) begin
    if (rst || state_q != SARC_CONVERT) begin
      trial_q <= MSB_TRIAL;
      bitMask_q <= MSB_TRIAL;
    end else if (decide) begin
      trial_q <= kept | (bitMask_q >> 1);
      bitMask_q <= bitMask_q >> 1;
    end
  end

  // result and one-cycle completion pulse
  always_ff @(posedge ref_clk) begin
    if (rst || abort) begin
      done <= 1'b0;
      result <= RESULT_RESET;
    end else begin
      done <= decide && (cnt_q == CONV_LAST);
      if (decide && (cnt_q == CONV_LAST)) begin
        result <= kept;
      end
    end
  end

  assign sampling = (state_q == SARC_SAMPLE);
  assign trialCode = trial_q;

endmodule
`default_nettype wire

// *** bench/sarc_monitor.sv ***
// port assertions for the sar converter control block
`default_nettype none
module sarc_monitor import sarc_pkg::*; #(
  parameter int unsigned CHANNELS = NUM_CHANNELS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // analog side
  input wire logic haltMode,
  input wire logic anaPowerOn,
  input wire logic [CHANNELS-1:0] anaChanSel,
  input wire logic anaSample,
  input wire logic [RES_BITS-1:0] dacCode
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take, wrCtrl_q, rdCtrl_q, brk_q, pwr_q;
  logic [2:0] chan_q;
  logic [5:0] sampCnt_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  assign take = hsel && hready && htrans == HTRANS_NONSEQ
    && haddr[9:2] == CTRL_IDX;
  // data-phase markers and shadow of the written fields
  always_ff @(posedge ref_clk) begin
    wrCtrl_q <= !rst && take && hwrite;
    rdCtrl_q <= !rst && take && !hwrite;
    pwr_q <= rst ? 1'b0 : wrCtrl_q ? hwdata[5] : pwr_q;
    chan_q <= rst ? 3'h0 : wrCtrl_q ? hwdata[2:0] : chan_q;
  end
  // sampling run length; a write restarts the run
  always_ff @(posedge ref_clk) begin
    if (rst || !anaSample || wrCtrl_q) sampCnt_q <= '0;
    else sampCnt_q <= sampCnt_q + 6'h1;
  end
  // conversion disturbed by a write or power loss, excused below
  always_ff @(posedge ref_clk) begin
    if (rst || wrCtrl_q || !anaPowerOn) brk_q <= 1'b1;
    else if ($fell(anaSample)) brk_q <= 1'b0;
  end
  // a fall caused by a write's abort is a restart, not a conversion start
  sequence convStart;
    $fell(anaSample) && anaPowerOn && !$past(wrCtrl_q);
  endsequence
  sequence convRun;
    ##31 (!anaSample || brk_q) ##1 (anaSample || brk_q || !anaPowerOn);
  endsequence
  AST_POWER: assert property (
    anaPowerOn == (pwr_q && !haltMode)) else $error("power mismatch");
  AST_OFF_NO_CHAN: assert property (
    !anaPowerOn |-> anaChanSel == '0) else $error("channel while off");
  AST_CHAN_SEL: assert property (
    anaPowerOn |-> anaChanSel == (CHANNELS'(1) << chan_q))
    else $error("wrong input selected");
  AST_SAMPLE_MAX: assert property (
    anaSample |-> sampCnt_q < 6'd32) else $error("sampling too long");
  AST_SAMPLE_FULL: assert property (
    $fell(anaSample) && anaPowerOn && !$past(wrCtrl_q)
    |-> $past(sampCnt_q) == 6'd31)
    else $error("sampling too short");
  AST_BUS_OKAY: assert property (
    hreadyout && hresp == HRESP_OKAY) else $error("bus response wrong");
  AST_CONV_PERIOD: assert property (
    convStart |-> convRun) else $error("conversion period wrong");
  AST_CTRL_READ: assert property (
    rdCtrl_q |-> hrdata[31:6] == {24'h0, hrdata[7], 1'b0}
    && hrdata[5:0] == {$past(pwr_q), 2'h0, $past(chan_q)})
    else $error("control readback wrong");
  AST_RESET_VAL: assert property (
    $past(rst) |-> !anaPowerOn && !anaSample && hrdata == '0
    && dacCode == 8'h80) else $error("reset values wrong");
endmodule
`default_nettype wire

// *** bench/sarc_src.sv ***
// analog source model: one level per input, as an ideal code
`default_nettype none
module sarc_src import sarc_pkg::*; (
  // analog front end
  input wire logic anaPowerOn,
  input wire logic [7:0] anaChanSel,
  input wire logic [RES_BITS-1:0] dacCode,
  input wire logic [7:0] lvl [8],
  // comparator
  output logic compHigh
);
  timeunit 1ns;
  timeprecision 1ns;
  // unpowered comparator gives no stable level, so it wobbles
  always_comb begin
    compHigh = dacCode[0];
    for (int i = 0; i < 8; i++)
      if (anaPowerOn && anaChanSel[i]) compHigh = lvl[i] >= dacCode;
  end
endmodule
`default_nettype wire

// *** bench/sarc_ctrl_bench.sv ***
// self-checking bench for the sar converter control block
`default_nettype none
module sarc_ctrl_bench import sarc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, haltMode = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic hreadyout, hresp, anaPowerOn, anaSample, compHigh;
  logic [7:0] anaChanSel, dacCode, rd;
  logic [7:0] lvl [8] = '{8'h00, 8'hff, 8'h5a, 8'h80, 8'h7f, 8'h01,
    8'hfe, 8'h33};
  int failures = 0, checks = 0;
  always #10 ref_clk = ~ref_clk;
  sarc_ctrl #(.SETTLE_LEN(8)) sarc_ctrl_inst (.ref_clk, .rst, .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .haltMode, .anaPowerOn, .anaChanSel,
    .anaSample, .dacCode, .compHigh);
  sarc_src sarc_src_inst (.anaPowerOn, .anaChanSel, .dacCode, .lvl,
    .compHigh);
  task automatic chk(string n, logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one bus phase, held until ready is seen
  task automatic hold;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic bus(logic w, logic [7:0] idx, logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= 32'({idx, 2'h0});
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hold();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= 32'(wd);
    hold();
    rd = hrdata[7:0];
  endtask
  // polls the control register; a missing flag ends the run
  task automatic waitFlag;
    int n;
    for (n = 0; n < 80; n++) begin
      bus(0, CTRL_IDX, 0);
      if (rd[FLAG_BIT] === 1'b1) break;
    end
    if (n >= 80) begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic resetRegs;
    bus(1, RESULT_IDX, 8'h5a);
    bus(0, RESULT_IDX, 0);
    chk("result", rd, 8'h00);
    bus(0, CTRL_IDX, 0);
    chk("ctrl", rd, 8'h00);
    bus(0, 8'h72, 0);
    chk("unmapped", rd, 8'h00);
  endtask
  task automatic allChannels;
    for (int c = 0; c < 8; c++) begin
      bus(1, CTRL_IDX, 8'h20 | 8'(c));
      waitFlag();
      chk("ctrl", rd, 8'ha0 | 8'(c));
      bus(0, RESULT_IDX, 0);
      chk("code", rd, lvl[c]);
      bus(0, CTRL_IDX, 0);
      chk("flag", rd, 8'h20 | 8'(c));
    end
  endtask
  task automatic abortRestart;
    // flag must be up so the write has something to clear
    waitFlag();
    bus(1, CTRL_IDX, 8'h37);
    bus(0, CTRL_IDX, 0);
    chk("bit4", rd, 8'h27);
    repeat (58) @(posedge ref_clk);
    bus(0, CTRL_IDX, 0);
    chk("early", rd, 8'h27);
    waitFlag();
    bus(0, RESULT_IDX, 0);
    chk("code", rd, lvl[7]);
    lvl[7] <= 8'h11;
    repeat (140) @(posedge ref_clk);
    bus(0, CTRL_IDX, 0);
    chk("ctrl", rd, 8'ha7);
    bus(0, RESULT_IDX, 0);
    chk("code", rd, 8'h11);
  endtask
  task automatic haltAndOff;
    haltMode <= 1'b1;
    bus(1, CTRL_IDX, 8'h22);
    repeat (100) @(posedge ref_clk);
    bus(0, CTRL_IDX, 0);
    chk("halt", rd, 8'h22);
    chk("power", anaPowerOn, 1'b0);
    haltMode <= 1'b0;
    waitFlag();
    bus(0, RESULT_IDX, 0);
    chk("code", rd, lvl[2]);
    bus(1, CTRL_IDX, 8'h00);
    repeat (100) @(posedge ref_clk);
    bus(0, CTRL_IDX, 0);
    chk("off", rd, 8'h00);
    chk("power", anaPowerOn, 1'b0);
  endtask
  task automatic midReset;
    bus(1, CTRL_IDX, 8'h21);
    waitFlag();
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    resetRegs();
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    resetRegs();
    allChannels();
    abortRestart();
    haltAndOff();
    midReset();
    print_verdict();
  end
endmodule
bind sarc_ctrl sarc_monitor #(.CHANNELS(CHANNELS)) sarc_monitor_inst (
  .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .haltMode, .anaPowerOn, .anaChanSel,
  .anaSample, .dacCode);
`default_nettype wire
